// *** core/tsrr_edge_detect.sv ***
module tsrr_edge_detect (
  input  wire logic i_clk,    // System clock.
  input  wire logic i_sys_rst,// Synchronous reset.
  input  wire logic i_level,  // Level to watch.
  output logic      o_rise    // Rising edge, combinational.
);

  logic prev;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      prev <= tsrr_pkg::TRG_RESET_VAL;
    end else begin
      prev <= i_level;
    end
  end

  assign o_rise = i_level & ~prev;

endmodule : tsrr_edge_detect

// *** core/tsrr_pkg.sv ***
package tsrr_pkg;

  // ****************************************
  // Reset values and encodings
  // ****************************************
  localparam logic OUT_RESET_VAL  = 1'h0;
  localparam logic TRG_RESET_VAL  = 1'h0;
  localparam logic PRIO_CLEAR_WINS = 1'h0;
  localparam logic PRIO_SET_WINS   = 1'h1;
  localparam logic MODE_TOGGLE     = 1'h0;
  localparam logic MODE_LATCHING   = 1'h1;

  typedef struct packed {
    logic mode;
    logic priority_sel;
    logic retentive;
  } tsrr_cfg_s;

  typedef struct packed {
    logic set_in;
    logic clear_in;
    logic toggle_pulse;
  } tsrr_in_s;

  typedef enum logic [2:0] {
    TSRR_ST_COLD  = 3'h1,
    TSRR_ST_RUN   = 3'h2,
    TSRR_ST_SPARE = 3'h4
  } tsrr_state_e;

endpackage : tsrr_pkg

// *** core/tsrr_relay.sv ***
module tsrr_relay (
  input  wire logic                i_clk,         // 50 MHz system clock.
  input  wire logic                i_sys_rst,     // Power-on reset, sync, high.
  input  wire tsrr_pkg::tsrr_cfg_s i_cfg,         // Mode, priority, retentivity.
  input  wire tsrr_pkg::tsrr_in_s  i_in,          // Set, clear and toggle inputs.
  output logic                     o_relay_out    // Relay output.
);

  // ****************************************
  // Edge detection
  // ****************************************
  logic toggle_rise;

  // The history flop clears on reset, so a toggle held high through the
  // release of reset counts as one edge.
  // Edge detect with a registered history flop and a combinational output.
  tsrr_edge_detect u_edge (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_level   (i_in.toggle_pulse),
    .o_rise    (toggle_rise)
  );

  // ****************************************
  // Input decode
  // ****************************************
  logic set_req;
  logic clear_req;
  logic mode_latch;
  logic set_wins;

  assign set_req    = i_in.set_in;
  assign clear_req  = i_in.clear_in;
  assign mode_latch = (i_cfg.mode == tsrr_pkg::MODE_LATCHING);
  assign set_wins   = (i_cfg.priority_sel == tsrr_pkg::PRIO_SET_WINS);

  // ****************************************
  // Toggle mode next value
  // ****************************************
  // The case walks the full table of set, clear and edge, so that an
  // edge meeting an active set or clear plainly has no effect.
  logic next_toggle_out;

  always_comb begin
    next_toggle_out = o_relay_out;
    case ({set_req, clear_req, toggle_rise})
      3'h0: begin
        next_toggle_out = o_relay_out;
      end
      3'h1: begin
        next_toggle_out = ~o_relay_out;
      end
      3'h2,
      3'h3: begin
        next_toggle_out = 1'h0;
      end
      3'h4,
      3'h5: begin
        next_toggle_out = 1'h1;
      end
      3'h6,
      3'h7: begin
        if (set_wins) begin
          next_toggle_out = 1'h1;
        end else begin
          next_toggle_out = 1'h0;
        end
      end
      default: begin
        next_toggle_out = o_relay_out;
      end
    endcase
  end

  // ****************************************
  // Latching mode next value
  // ****************************************
  logic next_latch_out;

  always_comb begin
    next_latch_out = o_relay_out;
    case ({set_req, clear_req})
      2'h0: begin
        next_latch_out = o_relay_out;
      end
      2'h1: begin
        next_latch_out = 1'h0;
      end
      2'h2: begin
        next_latch_out = 1'h1;
      end
      2'h3: begin
        next_latch_out = 1'h0;
      end
      default: begin
        next_latch_out = o_relay_out;
      end
    endcase
  end

  // ****************************************
  // Mode select
  // ****************************************
  // Priority and edges only matter in toggle mode; the latch ignores both.
  logic next_relay_out;

  always_comb begin
    if (mode_latch) begin
      next_relay_out = next_latch_out;
    end else begin
      next_relay_out = next_toggle_out;
    end
  end

  // ****************************************
  // Retained storage
  // ****************************************
  // This copy stands for the non-volatile cell of a retentive instance.
  // It follows the output while running and a retentive reset leaves it
  // alone, so the output is reloaded from it during the outage.
  logic kept_state;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      if (!i_cfg.retentive) begin
        kept_state <= tsrr_pkg::OUT_RESET_VAL;
      end else begin
        kept_state <= kept_state;
      end
    end else begin
      kept_state <= next_relay_out;
    end
  end

  // ****************************************
  // Output state and power-on handling
  // ****************************************
  // The reset stands for a power loss. A retentive instance keeps its
  // state through it, as if held in non-volatile storage.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      if (!i_cfg.retentive) begin
        o_relay_out <= tsrr_pkg::OUT_RESET_VAL;
      end else begin
        o_relay_out <= kept_state;
      end
    end else begin
      o_relay_out <= next_relay_out;
    end
  end

endmodule : tsrr_relay

// *** dv/tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic                i_clk = 1'h0;
  logic                i_sys_rst = 1'h1;
  logic                q;
  tsrr_pkg::tsrr_cfg_s cfg = 3'h0;
  tsrr_pkg::tsrr_in_s  in_s;
  int                  err_total, samples_checked, cyc;
  tsrr_src SRC (.i_clk(i_clk), .o_in(in_s));
  tsrr_relay DUT (.i_clk, .i_sys_rst, .i_cfg(cfg), .i_in(in_s), .o_relay_out(q));
  initial forever #10 i_clk = ~i_clk;
  always @(posedge i_clk) if (++cyc > 400) begin
    err_total++;
    stop_test();
  end
  task stop_test();
    $display("errors %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  task ck(input logic e);
    samples_checked++;
    if (q !== e) begin
      err_total++;
      $display("mismatch %0t got %b", $time, q);
    end
  endtask : ck
  task s(input logic [2:0] v, input logic e);
    SRC.put(v);
    @(negedge i_clk);
    ck(e);
  endtask : s
  task rs(input logic e);
    @(negedge i_clk);
    i_sys_rst = 1'h1;
    @(negedge i_clk);
    i_sys_rst = 1'h0;
    ck(e);
  endtask : rs
  task t_toggle();
    s(3'h1, 1'h1);
    s(3'h0, 1'h1);
    s(3'h1, 1'h0);
    s(3'h4, 1'h1);
    s(3'h5, 1'h1);
    s(3'h2, 1'h0);
    s(3'h3, 1'h0);
  endtask : t_toggle
  task t_prio();
    s(3'h4, 1'h1);
    s(3'h6, 1'h0);
    cfg.priority_sel = 1'h1;
    s(3'h2, 1'h0);
    s(3'h6, 1'h1);
    s(3'h7, 1'h1);
  endtask : t_prio
  task t_equiv();
    cfg.priority_sel = 1'h0;
    s(3'h4, 1'h1);
    s(3'h6, 1'h0);
    s(3'h0, 1'h0);
    s(3'h4, 1'h1);
    s(3'h0, 1'h1);
    s(3'h2, 1'h0);
  endtask : t_equiv
  task t_latch();
    cfg.mode = 1'h1;
    s(3'h6, 1'h0);
    s(3'h4, 1'h1);
    s(3'h0, 1'h1);
    s(3'h1, 1'h1);
    s(3'h2, 1'h0);
    s(3'h1, 1'h0);
    s(3'h0, 1'h0);
  endtask : t_latch
  task t_retain();
    s(3'h4, 1'h1);
    s(3'h0, 1'h1);
    cfg.retentive = 1'h1;
    rs(1'h1);
    s(3'h0, 1'h1);
    cfg.retentive = 1'h0;
    rs(1'h0);
    s(3'h4, 1'h1);
  endtask : t_retain
  initial begin
    repeat (6) @(negedge i_clk);
    i_sys_rst = 1'h0;
    t_toggle();
    t_prio();
    t_equiv();
    t_latch();
    t_retain();
    stop_test();
  end
endmodule : tb_top

// *** dv/tsrr_relay_asserts.sv ***
module tsrr_relay_asserts (
  input wire logic                i_clk,      // Clock.
  input wire logic                i_sys_rst,  // Reset.
  input wire tsrr_pkg::tsrr_cfg_s i_cfg,      // Config.
  input wire tsrr_pkg::tsrr_in_s  i_in,       // Inputs.
  input wire logic                o_relay_out // Output.
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic s = i_in.set_in;
  wire logic c = i_in.clear_in;
  wire logic m = i_cfg.mode;
  wire logic q = o_relay_out;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  property p_set; s && !c |=> q; endproperty
  a_set: assert property (p_set) else $error("set");
  property p_clr; c && !(s && i_cfg.priority_sel && !m) |=> !q; endproperty
  a_clr: assert property (p_clr) else $error("clear");
  property p_both; s && c && !m |=> q == $past(i_cfg.priority_sel); endproperty
  a_both: assert property (p_both) else $error("both");
  property p_tgl; !m && !s && !c && $rose(i_in.toggle_pulse) |=> q != $past(q); endproperty
  a_tgl: assert property (p_tgl) else $error("toggle");
  property p_hold; m && !s && !c |=> $stable(q); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_lat_both; m && s && c |=> !q; endproperty
  a_lat_both: assert property (p_lat_both) else $error("latch both");
  property p_keep; disable iff (1'h0) i_sys_rst && i_cfg.retentive |=> q == $past(q); endproperty
  a_keep: assert property (p_keep) else $error("retain");
  property p_cold; disable iff (1'h0) i_sys_rst && !i_cfg.retentive |=> !q; endproperty
  a_cold: assert property (p_cold) else $error("cold");
  c_tgl: cover property (!m && $rose(i_in.toggle_pulse));
  c_both: cover property (s && c);
  c_lat: cover property (m && s);
endmodule : tsrr_relay_asserts
bind tsrr_relay tsrr_relay_asserts u_chk (.i_clk, .i_sys_rst, .i_cfg, .i_in, .o_relay_out);

// *** dv/tsrr_src.sv ***
module tsrr_src (
  input  wire logic          i_clk, // Clock.
  output tsrr_pkg::tsrr_in_s o_in   // Driven inputs.
);
  timeunit 1ns;
  timeprecision 1ns;
  initial o_in = 3'h0;
  task put(input logic [2:0] v);
    @(negedge i_clk);
    o_in = v;
  endtask : put
endmodule : tsrr_src
